// [verification/iwdt_tb_top.sv]
`timescale 1ns/1ps
module iwdt_tb_top;
  import iwdt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  iwdt_sfr_req_t sfr_req = '0;
  logic rst_pin_in = 1'b0;
  logic [7:0] sfr_rdata;
  logic rst_pin_out, rst_pin_oe, device_reset, ports_force_high, port0_float;
  int mismatches = 0;
  int compares = 0;
  int n;
  always #25 clk = ~clk;
  // A short pulse keeps the overflow scenario inside the run budget.
  iwdt_top #(.PULSE_TICKS(4)) u_dut (.clk(clk), .reset(reset), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .device_reset(device_reset),
    .ports_force_high(ports_force_high), .port0_float(port0_float));
  task automatic close_out();
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask : sfr_write
  task automatic sfr_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    @(negedge clk);
    sfr_req.rd = 1'b0;
    @(negedge clk);
    cmp8("sfr_rdata", exp, sfr_rdata);
  endtask : sfr_check
  task automatic wait_reset(input logic lvl, input int limit);
    for (n = 0; n < limit && device_reset !== lvl; n++) @(negedge clk);
    cmp8("device_reset", {7'h00, lvl}, {7'h00, device_reset});
  endtask : wait_reset
  task automatic check_lock();
    sfr_check(IWDT_CTRL_ADDR, 8'hA5);
    sfr_check(IWDT_COUNT_ADDR, 8'h00);
    sfr_check(8'h33, 8'h00);
    sfr_write(IWDT_COUNT_ADDR, 8'h12);
    sfr_check(IWDT_COUNT_ADDR, 8'h00);
    sfr_write(IWDT_CTRL_ADDR, 8'h3C);
    sfr_check(IWDT_CTRL_ADDR, 8'h3C);
    sfr_write(IWDT_COUNT_ADDR, 8'h12);
    sfr_check(IWDT_COUNT_ADDR, 8'h00);
  endtask : check_lock
  task automatic check_overflow();
    sfr_write(IWDT_CTRL_ADDR, 8'h5A);
    sfr_write(IWDT_COUNT_ADDR, 8'hFF);
    sfr_check(IWDT_CTRL_ADDR, 8'h00);
    sfr_check(IWDT_COUNT_ADDR, 8'hFF);
    sfr_write(IWDT_COUNT_ADDR, 8'h10);
    sfr_check(IWDT_COUNT_ADDR, 8'hFF);
    // One count step is 2048 ticks of 20 clocks; stop just short of it.
    repeat (40800) @(negedge clk);
    cmp8("early_reset", 8'h00, {7'h00, device_reset});
    wait_reset(1'b1, 400);
    cmp8("pin_drive", 8'h03, {6'h00, rst_pin_oe, rst_pin_out});
    cmp8("ports", 8'h03, {6'h00, ports_force_high, port0_float});
    wait_reset(1'b0, 400);
    sfr_check(IWDT_CTRL_ADDR, 8'hA5);
    sfr_check(IWDT_COUNT_ADDR, 8'h00);
  endtask : check_overflow
  task automatic check_pin();
    @(negedge clk);
    rst_pin_in = 1'b1;
    wait_reset(1'b1, 10);
    cmp8("ports", 8'h03, {6'h00, ports_force_high, port0_float});
    sfr_write(IWDT_CTRL_ADDR, 8'h3C);
    rst_pin_in = 1'b0;
    wait_reset(1'b0, 10);
    sfr_check(IWDT_CTRL_ADDR, 8'hA5);
  endtask : check_pin
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    check_lock();
    check_overflow();
    check_pin();
    close_out();
  end
  initial begin
    #3000000;
    mismatches++;
    close_out();
  end
endmodule : iwdt_tb_top

// [verilog/iwdt_pkg.sv]
package iwdt_pkg;
  localparam logic [7:0] IWDT_CTRL_ADDR = 8'hA5;
  localparam logic [7:0] IWDT_COUNT_ADDR = 8'hFF;
  localparam logic [7:0] IWDT_CTRL_RESET = 8'hA5;
  localparam logic [7:0] IWDT_COUNT_RESET = 8'h00;
  localparam logic [7:0] IWDT_HALT_VALUE = 8'hA5;
  localparam logic [7:0] IWDT_UNLOCK_VALUE = 8'h5A;
  localparam logic [7:0] IWDT_CLEARED_CTRL = 8'h00;
  localparam int IWDT_PRESCALE_BITS = 11;
  localparam int IWDT_COUNT_BITS = 8;
  localparam int IWDT_CLK_HZ = 20000000;
  localparam int IWDT_OSC_HZ = 1000000;
  localparam int IWDT_OSC_DIV = IWDT_CLK_HZ / IWDT_OSC_HZ;
  localparam int IWDT_PULSE_MULT = 16;
  localparam int IWDT_PULSE_TICKS = IWDT_PULSE_MULT * 2048;
  localparam logic [4:0] IWDT_DIV_LAST = 5'(IWDT_OSC_DIV - 1);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iwdt_sfr_req_t;
endpackage : iwdt_pkg

// [verilog/iwdt_top.sv]
`timescale 1ns/1ps
module iwdt_top
  import iwdt_pkg::*;
#(
  parameter int PULSE_TICKS = IWDT_PULSE_TICKS
) (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic reset, // Power-on reset, synchronous, active high.
  input wire iwdt_sfr_req_t sfr_req, // Special function register access.
  output logic [7:0] sfr_rdata, // Read data, valid the cycle after a read.
  input wire logic rst_pin_in, // Level seen on the reset pin.
  output logic rst_pin_out, // Level driven on the reset pin.
  output logic rst_pin_oe, // High while the reset pin is driven.
  output logic device_reset, // Internal reset of the whole device.
  output logic ports_force_high, // Ports 1, 2 and 3 pulled high.
  output logic port0_float // Port 0 held in high impedance.
);
  localparam int PW = $clog2(PULSE_TICKS + 1);

  if (PULSE_TICKS < 2) begin : bad_pulse
    $error("PULSE_TICKS must be at least two");
  end

  logic [4:0] div_reg;
  logic tick_reg;
  logic [IWDT_PRESCALE_BITS-1:0] pre_reg;
  logic [IWDT_COUNT_BITS-1:0] count_reg;
  logic [7:0] ctrl_reg;
  logic pulse_reg;
  logic [PW-1:0] pulse_cnt_reg;
  logic [2:0] pin_sync_reg;
  logic pin_level_reg;
  logic halted;
  logic osc_run;
  logic int_rst;
  logic count_wr;
  logic unlocked_wr;
  logic pre_wrap;
  logic overflow;

  assign halted = (ctrl_reg == IWDT_HALT_VALUE);
  // The pulse keeps the oscillator alive although the control is back at the halt value.
  assign osc_run = !halted || pulse_reg;
  assign int_rst = pulse_reg || pin_level_reg;
  assign count_wr = sfr_req.wr && (sfr_req.addr == IWDT_COUNT_ADDR);
  assign unlocked_wr = count_wr && (ctrl_reg == IWDT_UNLOCK_VALUE) && !int_rst;
  assign pre_wrap = tick_reg && !halted && (pre_reg == '1);
  assign overflow = pre_wrap && (count_reg == '1) && !pulse_reg && !unlocked_wr;

  // The watchdog oscillator is modelled as a 1 MHz enable from the system clock; a real
  // part would keep it on its own ring oscillator so a stopped crystal cannot stall it.
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else if (!osc_run) begin
      div_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == IWDT_DIV_LAST);
      div_reg <= (div_reg == IWDT_DIV_LAST) ? 5'h00 : div_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || int_rst) begin
      ctrl_reg <= IWDT_CTRL_RESET;
    end else if (unlocked_wr) begin
      ctrl_reg <= IWDT_CLEARED_CTRL;
    end else if (sfr_req.wr && sfr_req.addr == IWDT_CTRL_ADDR) begin
      ctrl_reg <= sfr_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || halted) begin
      pre_reg <= '0;
      count_reg <= IWDT_COUNT_RESET;
    end else if (unlocked_wr) begin
      pre_reg <= '0;
      count_reg <= sfr_req.wdata;
    end else if (tick_reg) begin
      pre_reg <= pre_reg + 1'b1;
      if (pre_wrap) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // Only power-on reset stops the pulse before its count runs out; the reset it raises must not cut it short.
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else if (overflow) begin
      pulse_reg <= 1'b1;
      pulse_cnt_reg <= PW'(PULSE_TICKS - 1);
    end else if (pulse_reg && tick_reg) begin
      if (pulse_cnt_reg == '0) begin
        pulse_reg <= 1'b0;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
    end
  end

  // A pin level is trusted once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], rst_pin_in};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
      device_reset <= 1'b1;
      ports_force_high <= 1'b1;
      port0_float <= 1'b1;
    end else begin
      rst_pin_out <= pulse_reg;
      rst_pin_oe <= pulse_reg;
      device_reset <= int_rst;
      ports_force_high <= int_rst;
      port0_float <= int_rst;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        IWDT_CTRL_ADDR: sfr_rdata <= ctrl_reg;
        IWDT_COUNT_ADDR: sfr_rdata <= count_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_unlock_write;
    unlocked_wr ##0 (sfr_req.wdata != 8'h00);
  endsequence

  sequence s_pulse_out;
    pulse_reg ##1 rst_pin_oe && rst_pin_out;
  endsequence

  halt_clears_a: assert property (halted && !pulse_reg |=> pre_reg == '0 && count_reg == '0
    && !tick_reg) else $error("halted watchdog not cleared");
  reset_load_a: assert property (int_rst |=> ctrl_reg == IWDT_CTRL_RESET)
    else $error("control not reloaded by reset");
  locked_write_a: assert property (count_wr && ctrl_reg != IWDT_UNLOCK_VALUE && !tick_reg
    && !halted |=> count_reg == $past(count_reg)) else $error("locked write took");
  unlock_write_a: assert property (s_unlock_write |=> count_reg == $past(sfr_req.wdata)
    && pre_reg == '0 && ctrl_reg == IWDT_CLEARED_CTRL) else $error("unlock write bad");
  count_step_a: assert property (pre_wrap && !unlocked_wr && !int_rst
    |=> count_reg == $past(count_reg) + 8'h01) else $error("count did not step");
  overflow_pulse_a: assert property (overflow |=> s_pulse_out)
    else $error("overflow gave no pulse");
  pin_reset_a: assert property (pulse_reg |=> device_reset && ports_force_high
    && port0_float) else $error("internal reset not raised");
  read_live_a: assert property (sfr_req.rd && sfr_req.addr == IWDT_COUNT_ADDR
    |=> sfr_rdata == $past(count_reg)) else $error("count read wrong");
  pulse_runs_a: assert property (pulse_reg && tick_reg && pulse_cnt_reg != '0
    |=> pulse_cnt_reg == $past(pulse_cnt_reg) - 1'b1) else $error("pulse stalled");
  tick_space_a: assert property (tick_reg |=> !tick_reg [*8])
    else $error("oscillator ticks too close");

  // The checks below cover the enable chain, the two count stages and the reset outputs.
  // They are bounded to one or two cycles each so they stay cheap for the formal tools.

  // Counts oscillator ticks seen during a pulse so its length can be checked as a whole.
  logic [PW-1:0] pulse_seen_reg;

  always_ff @(posedge clk) begin
    if (reset || overflow) begin
      pulse_seen_reg <= '0;
    end else if (pulse_reg && tick_reg) begin
      pulse_seen_reg <= pulse_seen_reg + 1'b1;
    end
  end

  sequence s_tick_due;
    osc_run && (div_reg == IWDT_DIV_LAST);
  endsequence

  sequence s_pulse_last;
    pulse_reg && tick_reg && (pulse_cnt_reg == '0);
  endsequence

  sequence s_pin_agree;
    pin_sync_reg[1] == pin_sync_reg[2];
  endsequence

  // Oscillator enable chain.

  div_step_a: assert property (osc_run && div_reg != IWDT_DIV_LAST
    |=> div_reg == $past(div_reg) + 5'h01 && !tick_reg)
    else $error("divider did not step");

  tick_due_a: assert property (s_tick_due |=> tick_reg && div_reg == 5'h00)
    else $error("tick not raised at divider end");

  halt_div_a: assert property (!osc_run |=> div_reg == 5'h00 && !tick_reg)
    else $error("stopped oscillator still runs");

  // Prescaler and count stages.

  pre_step_a: assert property (tick_reg && !halted && !unlocked_wr
    |=> pre_reg == $past(pre_reg) + 1'b1)
    else $error("prescaler did not step");

  pre_hold_a: assert property (!tick_reg && !halted && !unlocked_wr
    |=> $stable(pre_reg))
    else $error("prescaler moved without tick");

  count_hold_a: assert property (!pre_wrap && !halted && !unlocked_wr
    |=> $stable(count_reg))
    else $error("count moved without wrap");

  unlock_any_a: assert property (unlocked_wr
    |=> pre_reg == '0 && count_reg == $past(sfr_req.wdata))
    else $error("accepted write not applied");

  relock_a: assert property (unlocked_wr |=> !unlocked_wr)
    else $error("count left unlocked");

  // Overflow and the stretched pulse.

  overflow_wrap_a: assert property (overflow |=> count_reg == 8'h00 && !overflow)
    else $error("overflow did not wrap once");

  pulse_load_a: assert property (overflow |=> pulse_cnt_reg == PW'(PULSE_TICKS - 1))
    else $error("pulse length not loaded");

  pulse_end_a: assert property (s_pulse_last |=> !pulse_reg)
    else $error("pulse did not end");

  pulse_keep_a: assert property (pulse_reg && !(tick_reg && pulse_cnt_reg == '0)
    |=> pulse_reg)
    else $error("pulse cut short");

  pulse_count_a: assert property ($fell(pulse_reg) |-> pulse_seen_reg == PW'(PULSE_TICKS))
    else $error("pulse tick total wrong");

  // Outputs to the pin and the rest of the device, and the filter on the pin input.

  pin_mirror_a: assert property (1'b1
    |=> rst_pin_out == $past(pulse_reg) && rst_pin_oe == $past(pulse_reg))
    else $error("pin drive does not follow pulse");

  reset_mirror_a: assert property (1'b1 |=> device_reset == $past(int_rst)
    && ports_force_high == $past(int_rst) && port0_float == $past(int_rst))
    else $error("reset outputs do not follow");

  pin_filter_a: assert property (s_pin_agree |=> pin_level_reg == $past(pin_sync_reg[2]))
    else $error("pin level not taken");

  pin_hold_a: assert property (pin_sync_reg[1] != pin_sync_reg[2] |=> $stable(pin_level_reg))
    else $error("pin level taken while unsettled");

  // Register access.

  ctrl_write_a: assert property (sfr_req.wr && sfr_req.addr == IWDT_CTRL_ADDR && !int_rst
    |=> ctrl_reg == $past(sfr_req.wdata))
    else $error("control write lost");

  ctrl_read_a: assert property (sfr_req.rd && sfr_req.addr == IWDT_CTRL_ADDR
    |=> sfr_rdata == $past(ctrl_reg))
    else $error("control read wrong");

  unmapped_read_a: assert property (sfr_req.rd && sfr_req.addr != IWDT_CTRL_ADDR
    && sfr_req.addr != IWDT_COUNT_ADDR |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
endmodule : iwdt_top
